// ===== core/hsv_consts.svh
// Constants for the host serial slave with access verification
`ifndef HSV_CONSTS_SVH
`define HSV_CONSTS_SVH

// ----------------------------------------
// Verification register offsets
// ----------------------------------------
`define HSV_ADDR_DATA8 16'hE7FC
`define HSV_ADDR_DATA16 16'hE6FF
`define HSV_ADDR_DATA32 16'hE5FF
`define HSV_ADDR_LAST_ADDR 16'hE6FE
`define HSV_ADDR_LAST_OPERATION_KIND 16'hE7FD

// ----------------------------------------
// Codes and reset values
// ----------------------------------------
`define HSV_OP_WRITE 8'hCA
`define HSV_OP_READ 8'h35
`define HSV_OP_RESET 8'h00
`define HSV_I2C_ADDR 7'h38
`define HSV_SS_TOGGLES 2'h3
`define HSV_HDR_BYTES 3'h3
`define HSV_HDR_LAST_BIT 6'h17
`define HSV_HDR_BITS 6'h18
`define HSV_BYTE_BITS 4'h8

// ----------------------------------------
// Timing
// ----------------------------------------
`define HSV_CLK_HZ 40000000
`define HSV_I2C_MAX_HZ 400000
`define HSV_SPI_MAX_HZ 2500000
`define HSV_I2C_HALF_CYC (`HSV_CLK_HZ / (2 * `HSV_I2C_MAX_HZ))
`define HSV_SPI_HALF_CYC (`HSV_CLK_HZ / (2 * `HSV_SPI_MAX_HZ))

`endif

// ===== core/hsv_pkg.sv
// Types for the host serial slave with access verification
package hsv_pkg;
    typedef enum logic [5:0] {
        HSV_IDLE = 6'h01,
        HSV_RXB = 6'h02,
        HSV_ACK = 6'h04,
        HSV_TXB = 6'h08,
        HSV_MACK = 6'h10,
        HSV_IGNORE = 6'h20
    } hsv_state_t;

    typedef enum logic [1:0] {
        HSV_SZ8 = 2'h0,
        HSV_SZ16 = 2'h1,
        HSV_SZ32 = 2'h2
    } hsv_size_t;
endpackage : hsv_pkg

// ===== core/hsv_slave.sv
// Host serial slave: I2C or SPI register access with verification registers
//
// Summary of operation
// - Successful access copies data to width-matched register
// - Last address latched until next success
// - Operation code 0xCA write, 0x35 read
// - Failed accesses leave verification registers alone
// - Reading verification registers pulses REG_RD but leaves the record alone
// - Hardware I2C slave, master at most 400 kHz
// - Shared pins, open-drain wired-AND drive only
// - Respond to slave address 0111000
// - Acknowledge every written byte, then stop
// - Read: pointer write, repeated start, 0x71 acknowledged
// - Read bytes MSB first, master NACKs last
// - SPI slave on master clock, at most 2.5 MHz
// - Sample on rising edge, shift out on falling
// - Output data floats when not transmitting
// - Chip select rising aborts and floats bus
// - Port chosen after reset by chip select toggles
`timescale 1ns/100ps
`include "hsv_consts.svh"

module hsv_slave
    import hsv_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic NRST,
    input wire logic SCL_SCLK,
    input wire logic SDA_MOSI,
    input wire logic SS_N,
    output logic SDA_O,
    output logic SDA_OE,
    output logic MISO_O,
    output logic MISO_OE,
    output logic SPI_SELECTED,
    output logic [15:0] REG_ADDR,
    output logic [31:0] REG_WDATA,
    output logic REG_WR,
    output logic REG_RD,
    input wire hsv_size_t REG_SIZE,
    input wire logic [31:0] REG_RDATA
);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [2:0] hsv_nbytes(input hsv_size_t sz);
        case (sz)
            HSV_SZ8: hsv_nbytes = 3'h1;
            HSV_SZ16: hsv_nbytes = 3'h2;
            default: hsv_nbytes = 3'h4;
        endcase
    endfunction : hsv_nbytes

    // Left-justify a value so its MSB leaves first
    function automatic logic [31:0] hsv_align(input logic [31:0] d, input hsv_size_t sz);
        case (sz)
            HSV_SZ8: hsv_align = {d[7:0], 24'h00_0000};
            HSV_SZ16: hsv_align = {d[15:0], 16'h0000};
            default: hsv_align = d;
        endcase
    endfunction : hsv_align

    // Right-justify a received value so no header bits leak upward
    function automatic logic [31:0] hsv_fit(input logic [31:0] d, input hsv_size_t sz);
        case (sz)
            HSV_SZ8: hsv_fit = {24'h00_0000, d[7:0]};
            HSV_SZ16: hsv_fit = {16'h0000, d[15:0]};
            default: hsv_fit = d;
        endcase
    endfunction : hsv_fit

    // Reads of the record itself must not disturb it
    function automatic logic hsv_is_verif(input logic [15:0] a);
        hsv_is_verif = (a == `HSV_ADDR_DATA8) || (a == `HSV_ADDR_DATA16)
            || (a == `HSV_ADDR_DATA32) || (a == `HSV_ADDR_LAST_ADDR) || (a == `HSV_ADDR_LAST_OPERATION_KIND);
    endfunction : hsv_is_verif

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic scl_m_reg, scl_s_reg, scl_d_reg;
    logic sda_m_reg, sda_s_reg, sda_d_reg;
    logic ss_m_reg, ss_s_reg, ss_d_reg;

    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            scl_m_reg <= 1'b1;
            scl_s_reg <= 1'b1;
            scl_d_reg <= 1'b1;
            sda_m_reg <= 1'b1;
            sda_s_reg <= 1'b1;
            sda_d_reg <= 1'b1;
            ss_m_reg <= 1'b1;
            ss_s_reg <= 1'b1;
            ss_d_reg <= 1'b1;
        end else begin
            scl_m_reg <= SCL_SCLK;
            scl_s_reg <= scl_m_reg;
            scl_d_reg <= scl_s_reg;
            sda_m_reg <= SDA_MOSI;
            sda_s_reg <= sda_m_reg;
            sda_d_reg <= sda_s_reg;
            ss_m_reg <= SS_N;
            ss_s_reg <= ss_m_reg;
            ss_d_reg <= ss_s_reg;
        end
    end

    logic clk_rise, clk_fall, i2c_start, i2c_stop, ss_fall;
    assign clk_rise = scl_s_reg & ~scl_d_reg;
    assign clk_fall = ~scl_s_reg & scl_d_reg;
    assign i2c_start = scl_s_reg & scl_d_reg & sda_d_reg & ~sda_s_reg;
    assign i2c_stop = scl_s_reg & scl_d_reg & ~sda_d_reg & sda_s_reg;
    assign ss_fall = ss_d_reg & ~ss_s_reg;

    // ----------------------------------------
    // State
    // ----------------------------------------
    hsv_state_t state_reg, state_next;
    logic mode_spi_reg, mode_spi_next;
    logic [1:0] ss_cnt_reg, ss_cnt_next;
    logic [5:0] cnt_reg, cnt_next;
    logic [2:0] bidx_reg, bidx_next;
    logic over_reg, over_next;
    logic rw_reg, rw_next;
    logic [31:0] sh_reg, sh_next;
    logic [31:0] dat_reg, dat_next;
    logic [15:0] ptr_reg, ptr_next;
    logic sda_oe_reg, sda_oe_next;
    logic miso_reg, miso_next;
    logic miso_oe_reg, miso_oe_next;
    logic wr_reg, wr_next;
    logic rd_reg, rd_next;
    logic [31:0] wdata_reg, wdata_next;
    logic [7:0] last_operation_kind_reg, last_operation_kind_next;
    logic [15:0] last_addr_reg, last_addr_next;
    logic [7:0] last8_reg, last8_next;
    logic [15:0] last16_reg, last16_next;
    logic [31:0] last32_reg, last32_next;

    logic commit_wr, commit_rd, commit_any;
    logic [31:0] commit_data, rdval, rd_aligned;
    logic [2:0] nb;
    logic [5:0] spi_end;

    assign nb = hsv_nbytes(REG_SIZE);
    assign spi_end = `HSV_HDR_LAST_BIT + {nb, 3'h0};
    assign commit_any = commit_wr | (commit_rd & ~hsv_is_verif(ptr_reg));
    assign rd_aligned = hsv_align(rdval, REG_SIZE);

    // Local verification registers answer reads themselves, read-only
    always_comb begin
        case (ptr_reg)
            `HSV_ADDR_DATA8: rdval = {24'h00_0000, last8_reg};
            `HSV_ADDR_DATA16: rdval = {16'h0000, last16_reg};
            `HSV_ADDR_DATA32: rdval = last32_reg;
            `HSV_ADDR_LAST_ADDR: rdval = {16'h0000, last_addr_reg};
            `HSV_ADDR_LAST_OPERATION_KIND: rdval = {24'h00_0000, last_operation_kind_reg};
            default: rdval = REG_RDATA;
        endcase
    end

    // ----------------------------------------
    // Protocol engines
    // ----------------------------------------
    always_comb begin
        state_next = state_reg;
        mode_spi_next = mode_spi_reg;
        ss_cnt_next = ss_cnt_reg;
        cnt_next = cnt_reg;
        bidx_next = bidx_reg;
        over_next = over_reg;
        rw_next = rw_reg;
        sh_next = sh_reg;
        dat_next = dat_reg;
        ptr_next = ptr_reg;
        sda_oe_next = sda_oe_reg;
        miso_next = miso_reg;
        miso_oe_next = miso_oe_reg;
        rd_next = 1'b0;
        commit_wr = 1'b0;
        commit_rd = 1'b0;
        commit_data = dat_reg;
        // Port choice holds until the next hardware reset
        if (!mode_spi_reg && ss_fall) begin
            ss_cnt_next = ss_cnt_reg + 2'h1;
            if (ss_cnt_reg == `HSV_SS_TOGGLES - 2'h1) begin
                mode_spi_next = 1'b1;
                state_next = HSV_IDLE;
                sda_oe_next = 1'b0;
            end
        end else if (!mode_spi_reg) begin
            if (i2c_start) begin
                state_next = HSV_RXB;
                cnt_next = 6'h00;
                bidx_next = 3'h0;
                over_next = 1'b0;
                sda_oe_next = 1'b0;
            end else if (i2c_stop) begin
                // Write counts only with exactly the register's width received
                if (!rw_reg && !over_reg && state_reg == HSV_RXB
                    && bidx_reg == `HSV_HDR_BYTES + nb) begin
                    commit_wr = 1'b1;
                end
                state_next = HSV_IDLE;
                sda_oe_next = 1'b0;
            end else begin
                case (state_reg)
                    HSV_RXB: begin
                        if (clk_rise) begin
                            sh_next = {sh_reg[30:0], sda_s_reg};
                            cnt_next = cnt_reg + 6'h01;
                        end else if (clk_fall && cnt_reg == {2'h0, `HSV_BYTE_BITS}) begin
                            cnt_next = 6'h00;
                            state_next = HSV_ACK;
                            sda_oe_next = 1'b1;
                            case (bidx_reg)
                                3'h0: begin
                                    if (sh_reg[7:1] == `HSV_I2C_ADDR) begin
                                        rw_next = sh_reg[0];
                                        bidx_next = sh_reg[0] ? `HSV_HDR_BYTES : 3'h1;
                                        if (sh_reg[0]) begin
                                            rd_next = 1'b1;
                                            dat_next = rdval;
                                            sh_next = rd_aligned;
                                        end
                                    end else begin
                                        state_next = HSV_IGNORE;
                                        sda_oe_next = 1'b0;
                                    end
                                end
                                3'h1: begin
                                    ptr_next[15:8] = sh_reg[7:0];
                                    bidx_next = 3'h2;
                                end
                                3'h2: begin
                                    ptr_next[7:0] = sh_reg[7:0];
                                    bidx_next = 3'h3;
                                end
                                default: begin
                                    dat_next = {dat_reg[23:0], sh_reg[7:0]};
                                    // Counter saturates, so a fifth byte is flagged instead
                                    if (bidx_reg != 3'h7) begin
                                        bidx_next = bidx_reg + 3'h1;
                                    end else begin
                                        over_next = 1'b1;
                                    end
                                end
                            endcase
                        end
                    end
                    HSV_ACK: begin
                        if (clk_fall) begin
                            if (rw_reg) begin
                                sda_oe_next = ~sh_reg[31];
                                sh_next = {sh_reg[30:0], 1'b0};
                                cnt_next = 6'h01;
                                state_next = HSV_TXB;
                            end else begin
                                sda_oe_next = 1'b0;
                                state_next = HSV_RXB;
                            end
                        end
                    end
                    HSV_TXB: begin
                        if (clk_fall) begin
                            if (cnt_reg == {2'h0, `HSV_BYTE_BITS}) begin
                                sda_oe_next = 1'b0;
                                cnt_next = 6'h00;
                                state_next = HSV_MACK;
                            end else begin
                                sda_oe_next = ~sh_reg[31];
                                sh_next = {sh_reg[30:0], 1'b0};
                                cnt_next = cnt_reg + 6'h01;
                            end
                        end
                    end
                    HSV_MACK: begin
                        if (clk_rise) begin
                            bidx_next = bidx_reg + 3'h1;
                            if (sda_s_reg) begin
                                // Early NACK leaves the record untouched
                                commit_rd = (bidx_reg + 3'h1 == `HSV_HDR_BYTES + nb);
                                state_next = HSV_IGNORE;
                            end else begin
                                state_next = HSV_TXB;
                            end
                        end
                    end
                    HSV_IDLE, HSV_IGNORE: begin
                        state_next = state_reg;
                    end
                    default: begin
                        state_next = HSV_IDLE;
                    end
                endcase
            end
        end else if (ss_s_reg) begin
            cnt_next = 6'h00;
            miso_oe_next = 1'b0;
        end else begin
            if (clk_rise) begin
                if (!(rw_reg && cnt_reg >= `HSV_HDR_BITS)) begin
                    sh_next = {sh_reg[30:0], sda_s_reg};
                end
                if (cnt_reg != 6'h3F) begin
                    cnt_next = cnt_reg + 6'h01;
                end
                if (cnt_reg == 6'h07) begin
                    rw_next = sda_s_reg;
                end
                if (cnt_reg == `HSV_HDR_LAST_BIT) begin
                    ptr_next = {sh_reg[14:0], sda_s_reg};
                end
                if (cnt_reg == spi_end && cnt_reg > `HSV_HDR_LAST_BIT) begin
                    commit_wr = ~rw_reg;
                    commit_rd = rw_reg;
                    if (!rw_reg) begin
                        commit_data = {sh_reg[30:0], sda_s_reg};
                        dat_next = commit_data;
                    end
                end
            end else if (clk_fall && rw_reg && cnt_reg >= `HSV_HDR_BITS) begin
                miso_oe_next = 1'b1;
                if (cnt_reg == `HSV_HDR_BITS) begin
                    rd_next = 1'b1;
                    dat_next = rdval;
                    miso_next = rd_aligned[31];
                    sh_next = {rd_aligned[30:0], 1'b0};
                end else begin
                    miso_next = sh_reg[31];
                    sh_next = {sh_reg[30:0], 1'b0};
                end
            end
        end
    end

    // ----------------------------------------
    // Verification record and register port
    // ----------------------------------------
    always_comb begin
        last_operation_kind_next = last_operation_kind_reg;
        last_addr_next = last_addr_reg;
        last8_next = last8_reg;
        last16_next = last16_reg;
        last32_next = last32_reg;
        wdata_next = wdata_reg;
        wr_next = commit_wr;
        if (commit_wr) begin
            wdata_next = hsv_fit(commit_data, REG_SIZE);
        end
        // Only a completed access moves the record
        if (commit_any) begin
            last_operation_kind_next = commit_wr ? `HSV_OP_WRITE : `HSV_OP_READ;
            last_addr_next = ptr_reg;
            case (REG_SIZE)
                HSV_SZ8: last8_next = commit_data[7:0];
                HSV_SZ16: last16_next = commit_data[15:0];
                default: last32_next = commit_data;
            endcase
        end
    end

    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            state_reg <= HSV_IDLE;
            mode_spi_reg <= 1'b0;
            ss_cnt_reg <= 2'h0;
            cnt_reg <= 6'h00;
            bidx_reg <= 3'h0;
            over_reg <= 1'b0;
            rw_reg <= 1'b0;
            sh_reg <= 32'h0000_0000;
            dat_reg <= 32'h0000_0000;
            ptr_reg <= 16'h0000;
            sda_oe_reg <= 1'b0;
            miso_reg <= 1'b0;
            miso_oe_reg <= 1'b0;
            wr_reg <= 1'b0;
            rd_reg <= 1'b0;
            wdata_reg <= 32'h0000_0000;
            last_operation_kind_reg <= `HSV_OP_RESET;
            last_addr_reg <= 16'h0000;
            last8_reg <= 8'h00;
            last16_reg <= 16'h0000;
            last32_reg <= 32'h0000_0000;
        end else begin
            state_reg <= state_next;
            mode_spi_reg <= mode_spi_next;
            ss_cnt_reg <= ss_cnt_next;
            cnt_reg <= cnt_next;
            bidx_reg <= bidx_next;
            over_reg <= over_next;
            rw_reg <= rw_next;
            sh_reg <= sh_next;
            dat_reg <= dat_next;
            ptr_reg <= ptr_next;
            sda_oe_reg <= sda_oe_next;
            miso_reg <= miso_next;
            miso_oe_reg <= miso_oe_next;
            wr_reg <= wr_next;
            rd_reg <= rd_next;
            wdata_reg <= wdata_next;
            last_operation_kind_reg <= last_operation_kind_next;
            last_addr_reg <= last_addr_next;
            last8_reg <= last8_next;
            last16_reg <= last16_next;
            last32_reg <= last32_next;
        end
    end

    // Open drain: the data output only ever pulls low
    assign SDA_O = 1'b0;
    assign SDA_OE = sda_oe_reg;
    assign MISO_O = miso_reg;
    assign MISO_OE = miso_oe_reg;
    assign SPI_SELECTED = mode_spi_reg;
    assign REG_ADDR = ptr_reg;
    assign REG_WDATA = wdata_reg;
    assign REG_WR = wr_reg;
    assign REG_RD = rd_reg;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_op_write: assert property (@(posedge CORE_CLK) disable iff (!NRST)
        commit_wr |=> last_operation_kind_reg == `HSV_OP_WRITE && wr_reg) else $error("write code wrong");
    a_op_read: assert property (@(posedge CORE_CLK) disable iff (!NRST)
        commit_rd && commit_any |=> last_operation_kind_reg == `HSV_OP_READ && !wr_reg)
        else $error("read code wrong");
    a_verif_quiet: assert property (@(posedge CORE_CLK) disable iff (!NRST)
        commit_rd && hsv_is_verif(ptr_reg) |=> $stable(last_operation_kind_reg) && $stable(last_addr_reg))
        else $error("record moved by its own read");
    a_record_hold: assert property (@(posedge CORE_CLK) disable iff (!NRST)
        !commit_any |=> $stable(last_addr_reg) && $stable(last32_reg) && $stable(last_operation_kind_reg))
        else $error("record moved without success");
    a_addr_latch: assert property (@(posedge CORE_CLK) disable iff (!NRST)
        commit_any |=> last_addr_reg == $past(ptr_reg)) else $error("address not latched");
    a_data8_copy: assert property (@(posedge CORE_CLK) disable iff (!NRST)
        commit_any && REG_SIZE == HSV_SZ8 |=> last8_reg == $past(commit_data[7:0]))
        else $error("byte record wrong");
    a_nack_foreign: assert property (@(posedge CORE_CLK) disable iff (!NRST)
        !mode_spi_reg && state_reg == HSV_RXB && clk_fall && !ss_fall && !i2c_start && !i2c_stop
        && cnt_reg == 6'h08 && bidx_reg == 3'h0 && sh_reg[7:1] != `HSV_I2C_ADDR
        |=> state_reg == HSV_IGNORE && !SDA_OE [*2]) else $error("foreign address acked");
    a_miso_float: assert property (@(posedge CORE_CLK) disable iff (!NRST)
        mode_spi_reg && ss_s_reg |=> !MISO_OE) else $error("miso driven while deselected");
    a_port_lock: assert property (@(posedge CORE_CLK) disable iff (!NRST)
        mode_spi_reg |=> mode_spi_reg && !SDA_OE) else $error("port choice changed");
    a_spi_count: assert property (@(posedge CORE_CLK) disable iff (!NRST)
        mode_spi_reg && !ss_s_reg && clk_rise && cnt_reg < 6'h20 |=> cnt_reg == $past(cnt_reg) + 6'h01)
        else $error("spi bit not counted");

endmodule : hsv_slave

// ===== tb/hsv_host.sv
// Host master model driving the shared serial pins as I2C or SPI master
`timescale 1ns/100ps

module hsv_host (
    input wire logic clk,
    input wire logic sda_in,
    input wire logic miso_in,
    output logic scl,
    output logic sda_low,
    output logic ss_n
);
    // ----------------------------------------
    // Pacing: quarter bit of 2 clocks, 200 ns per bit
    // ----------------------------------------
    task automatic q();
        repeat (2) @(posedge clk);
        #1;
    endtask : q

    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
        ss_n = 1'b1;
    end

    // ----------------------------------------
    // I2C: data only pulled low or released
    // ----------------------------------------
    task automatic bit_io(input logic low, output logic seen);
        sda_low = low;
        q();
        scl = 1'b1;
        q();
        seen = sda_in;
        q();
        scl = 1'b0;
        q();
    endtask : bit_io

    task automatic start();
        sda_low = 1'b0;
        q();
        scl = 1'b1;
        q();
        sda_low = 1'b1;
        q();
        scl = 1'b0;
        q();
    endtask : start

    // Extra quarters give the slave time to commit after stop
    task automatic stop();
        sda_low = 1'b1;
        q();
        scl = 1'b1;
        q();
        sda_low = 1'b0;
        repeat (4) q();
    endtask : stop

    task automatic byte_io(input logic [7:0] out, input logic mack, output logic [7:0] in,
                           output logic ack);
        logic k;
        for (int i = 7; i >= 0; i--) begin
            bit_io(!out[i], k);
            in[i] = k;
        end
        bit_io(mack, k);
        ack = !k;
    endtask : byte_io

    task automatic i2c_wr(input logic [7:0] sa, input logic [15:0] a, input logic [39:0] d,
                          input int n, output logic [7:0] acks);
        logic [7:0] junk;
        logic k;
        acks = 8'h00;
        start();
        byte_io(sa, 1'b0, junk, k);
        acks[0] = k;
        byte_io(a[15:8], 1'b0, junk, k);
        acks[1] = k;
        byte_io(a[7:0], 1'b0, junk, k);
        acks[2] = k;
        for (int i = 0; i < n; i++) begin
            byte_io(d[8*(n-1-i) +: 8], 1'b0, junk, k);
            acks[3+i] = k;
        end
        stop();
    endtask : i2c_wr

    task automatic i2c_rd(input logic [15:0] a, input int n, output logic [31:0] d);
        logic [7:0] b;
        logic k;
        d = 32'h0;
        start();
        byte_io(8'h70, 1'b0, b, k);
        byte_io(a[15:8], 1'b0, b, k);
        byte_io(a[7:0], 1'b0, b, k);
        start();
        byte_io(8'h71, 1'b0, b, k);
        for (int i = 0; i < n; i++) begin
            byte_io(8'hFF, i != n - 1, b, k);
            d = {d[23:0], b};
        end
        stop();
    endtask : i2c_rd

    // ----------------------------------------
    // SPI: select held low for the frame, data changed on falls
    // ----------------------------------------
    task automatic select_spi();
        repeat (3) begin
            ss_n = 1'b0;
            q();
            ss_n = 1'b1;
            q();
        end
    endtask : select_spi

    // Fewer than the full bit count aborts the frame on purpose
    task automatic spi_xfer(input logic [55:0] out, input int n, output logic [31:0] in);
        ss_n = 1'b0;
        q();
        for (int i = 0; i < n; i++) begin
            scl = 1'b0;
            sda_low = !out[55-i];
            q();
            q();
            scl = 1'b1;
            in = {in[30:0], miso_in};
            q();
            q();
        end
        ss_n = 1'b1;
        sda_low = 1'b0;
        q();
        q();
    endtask : spi_xfer
endmodule : hsv_host

// ===== tb/hsv_slave_tb.sv
// Testbench for the host serial slave with access verification
`timescale 1ns/100ps

module hsv_slave_tb
    import hsv_pkg::*;
;

    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic scl, sda_low, ss_n, sda_o, sda_oe, miso_o, miso_oe, spi_sel, reg_wr, reg_rd;
    logic miso_last = 1'b0;
    logic [15:0] reg_addr;
    logic [31:0] reg_wdata, rd;
    logic [7:0] acks;
    hsv_size_t reg_size;
    int error_cnt = 0;
    int samples_checked = 0;
    int wr_cnt = 0;
    int rd_cnt = 0;
    // Pull-up on data; a released data-out line shows the inverse of its last bit
    wire sda = !(sda_low | sda_oe);
    wire miso = miso_oe ? miso_o : !miso_last;
    wire [31:0] reg_rdata = {reg_addr, ~reg_addr};

    always #12.5 core_clk = ~core_clk;

    always_comb begin
        case (reg_addr)
            16'h1234, 16'hE7FC, 16'hE7FD: reg_size = HSV_SZ8;
            16'h2000, 16'hE6FE, 16'hE6FF: reg_size = HSV_SZ16;
            default: reg_size = HSV_SZ32;
        endcase
    end

    always @(posedge core_clk) begin
        if (miso_oe === 1'b1) begin
            miso_last <= miso_o;
        end
        if (reg_wr === 1'b1) begin
            wr_cnt <= wr_cnt + 1;
        end
        if (reg_rd === 1'b1) begin
            rd_cnt <= rd_cnt + 1;
        end
    end

    hsv_slave dut (.CORE_CLK(core_clk), .NRST(nrst), .SCL_SCLK(scl), .SDA_MOSI(sda),
        .SS_N(ss_n), .SDA_O(sda_o), .SDA_OE(sda_oe), .MISO_O(miso_o), .MISO_OE(miso_oe),
        .SPI_SELECTED(spi_sel), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr),
        .REG_RD(reg_rd), .REG_SIZE(reg_size), .REG_RDATA(reg_rdata));

    hsv_host host (.clk(core_clk), .sda_in(sda), .miso_in(miso), .scl(scl),
        .sda_low(sda_low), .ss_n(ss_n));

    // ----------------------------------------
    // Checking and closing
    // ----------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic tally_and_finish();
        $display("Checks %0d, mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : tally_and_finish

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_i2c_write();
        host.i2c_wr(8'h70, 16'h1234, 40'hA5, 1, acks);
        chk(acks, 8'h0F);
        chk(wr_cnt, 1);
        chk(reg_addr, 16'h1234);
        chk(reg_wdata, 32'hA5);
        chk(sda_o, 1'b0);
        host.i2c_rd(16'hE7FD, 1, rd);
        chk(rd, 32'hCA);
        host.i2c_rd(16'hE6FE, 2, rd);
        chk(rd, 32'h1234);
        host.i2c_rd(16'hE7FC, 1, rd);
        chk(rd, 32'hA5);
        chk(rd_cnt, 3);
    endtask : t_i2c_write

    task automatic t_i2c_read();
        host.i2c_rd(16'h2000, 2, rd);
        chk(rd, 32'hDFFF);
        host.i2c_rd(16'hE7FD, 1, rd);
        chk(rd, 32'h35);
        host.i2c_rd(16'hE6FF, 2, rd);
        chk(rd, 32'hDFFF);
        host.i2c_rd(16'hE6FE, 2, rd);
        chk(rd, 32'h2000);
    endtask : t_i2c_read

    // Foreign address, then a write one byte too long
    task automatic t_refused();
        host.i2c_wr(8'h72, 16'h5555, 40'h11, 1, acks);
        chk(acks, 8'h00);
        host.i2c_wr(8'h70, 16'h3000, 40'h01_0203_0405, 5, acks);
        chk(acks, 8'hFF);
        chk(wr_cnt, 1);
        host.i2c_rd(16'hE6FE, 2, rd);
        chk(rd, 32'h2000);
    endtask : t_refused

    task automatic t_spi();
        host.select_spi();
        repeat (8) @(posedge core_clk);
        chk(spi_sel, 1'b1);
        chk(miso_oe, 1'b0);
        host.spi_xfer({8'h00, 16'h4000, 32'h1234_5678}, 56, rd);
        chk(wr_cnt, 2);
        chk(reg_wdata, 32'h1234_5678);
        host.spi_xfer({8'h01, 16'hE5FF, 32'h0}, 56, rd);
        chk(rd, 32'h1234_5678);
        host.spi_xfer({8'h00, 16'h1234, 32'h9900_0000}, 30, rd);
        chk(wr_cnt, 2);
        chk(miso_oe, 1'b0);
        host.spi_xfer({8'h01, 16'hE6FE, 32'h0}, 40, rd);
        chk(rd[15:0], 16'h4000);
        host.spi_xfer({8'h01, 16'hE7FD, 32'h0}, 32, rd);
        chk(rd[7:0], 8'hCA);
    endtask : t_spi

    initial begin
        repeat (3) @(posedge core_clk);
        #1;
        nrst = 1'b1;
        repeat (6) @(posedge core_clk);
        t_i2c_write();
        t_i2c_read();
        t_refused();
        t_spi();
        tally_and_finish();
    end

    // Whole run needs well under 1 ms
    initial begin
        #1_000_000;
        error_cnt++;
        tally_and_finish();
    end
endmodule : hsv_slave_tb
